// File: design/shp_pkg.sv
// constants, exception numbers and bit-position helpers for the system handler block
package shp_pkg;

	// register addresses
	localparam logic [31:0] SHP_SCB_BASE  = 32'he000ed00;
	localparam logic [31:0] SHP_ADDR_PRIO = 32'he000ed20;
	localparam logic [31:0] SHP_OFF_HCS   = 32'h00000024;
	localparam logic [31:0] SHP_ADDR_HCS  = SHP_SCB_BASE + SHP_OFF_HCS;

	// reset values
	localparam logic [31:0] SHP_RST_WORD = 32'h00000000;
	localparam logic [3:0]  SHP_RST_PRIO = 4'h0;
	localparam logic [2:0]  SHP_RST_ENA  = 3'h0;

	// priority register layout
	localparam int SHP_TICK_LANE  = 3;
	localparam int SHP_DEFER_LANE = 2;
	localparam int SHP_PRIO_IMPL  = 4;

	// control and state register layout
	localparam int SHP_ENA_LSB  = 16;
	localparam int SHP_PEND_LSB = 12;
	localparam int SHP_N_PEND   = 4;
	localparam int SHP_N_ACT    = 7;
	localparam int SHP_N_FAULT  = 3;
	localparam logic [31:0] SHP_HCS_MASK = 32'h0007fd8b;

	// handler numbers as seen by the core
	typedef enum logic [3:0] {
		SHP_EXC_MEM   = 4'h4,
		SHP_EXC_BUS   = 4'h5,
		SHP_EXC_USAGE = 4'h6,
		SHP_EXC_SVC   = 4'hb,
		SHP_EXC_MON   = 4'hc,
		SHP_EXC_DEFER = 4'he,
		SHP_EXC_TICK  = 4'hf
	} shp_exc_t;

	// bit position of active flag k: mem, bus, usage, svc, monitor, deferred, tick
	function automatic int shp_act_pos(input int k);
		int p;
		p = 0;
		case (k)
			0:       p = 0;
			1:       p = 1;
			2:       p = 3;
			3:       p = 7;
			4:       p = 8;
			5:       p = 10;
			default: p = 11;
		endcase
		return p;
	endfunction

	// one-hot active index for a handler number
	function automatic logic [6:0] shp_act_sel(input shp_exc_t id);
		logic [6:0] s;
		s = 7'h00;
		case (id)
			SHP_EXC_MEM:   s = 7'h01;
			SHP_EXC_BUS:   s = 7'h02;
			SHP_EXC_USAGE: s = 7'h04;
			SHP_EXC_SVC:   s = 7'h08;
			SHP_EXC_MON:   s = 7'h10;
			SHP_EXC_DEFER: s = 7'h20;
			SHP_EXC_TICK:  s = 7'h40;
			default:       s = 7'h00;
		endcase
		return s;
	endfunction

	// one-hot pending index: usage, mem, bus, svc (bits 12..15)
	function automatic logic [3:0] shp_pend_sel(input shp_exc_t id);
		logic [3:0] s;
		s = 4'h0;
		case (id)
			SHP_EXC_USAGE: s = 4'h1;
			SHP_EXC_MEM:   s = 4'h2;
			SHP_EXC_BUS:   s = 4'h4;
			SHP_EXC_SVC:   s = 4'h8;
			default:       s = 4'h0;
		endcase
		return s;
	endfunction

	// byte enables widened to a bit mask
	function automatic logic [31:0] shp_be_mask(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

endpackage

// File: design/shp_prio_byte.sv
// one eight-bit priority field with only the upper nibble stored
module shp_prio_byte
	import shp_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rstn,
	// write port
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_byte,
	// field value
	output logic      [7:0] field
);
	import shp_pkg::*;

	logic [3:0] prio_q;
	logic [3:0] prio_d;

	always_comb begin
		prio_d = prio_q;
		if (wr_en) begin
			// low nibble dropped [RQ2]
			prio_d = wr_byte[7:SHP_PRIO_IMPL];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			prio_q <= SHP_RST_PRIO;
		end else begin
			prio_q <= prio_d;
		end
	end

	assign field = {prio_q, 4'h0}; // [RQ2]

endmodule

// File: design/shp_state_bit.sv
// one pending or active flag shared between software and the core
module shp_state_bit (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rstn,
	// software side
	input  wire logic sw_we,
	input  wire logic sw_val,
	// core side
	input  wire logic hw_set,
	input  wire logic hw_clr,
	// flag
	output logic      state
);

	logic state_q;
	logic state_d;

	// core set beats everything so an event is never lost to a write
	always_comb begin
		state_d = state_q;
		if (sw_we) begin
			state_d = sw_val;
		end
		if (hw_clr) begin
			state_d = 1'b0;
		end
		if (hw_set) begin
			state_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	assign state = state_q;

endmodule

// File: design/shp_handler_state.sv
// system handler priorities, enables, pending and active state
// What the document asks of this block and of software
// [RQ1] tick priority bits 31:24, deferred 23:16
// [RQ2] priority low nibble reads zero, ignores writes
// [RQ3] priority fields 0..255, byte or word writes
// [RQ4] software keeps priority bits 15:0 zero
// [RQ5] fault enables at bits 18, 17, 16
// [RQ6] disabled configurable fault escalates to hard fault
// [RQ7] pending bits 15..12 show pending state
// [RQ8] software write sets pending to written value
// [RQ9] active bits show active handler state
// [RQ10] software write sets active to written value
// [RQ11] unadjusted active change may fault on return
// [RQ12] software preserves and restores active status
// [RQ13] software uses read-modify-write once enabled
// [RQ14] software writes zero to reserved bits
// [RQ15] privileged access only, all zero at reset
// [RQ16] reserved bits read zero, writes ignored
// [RQ17] software changes visible by next instruction
//
// The plain strobed port was chosen for this implementation.
module shp_handler_state
	import shp_pkg::*;
(
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rstn,
	// register port
	input  wire logic [31:0]            reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic [3:0]             reg_be,
	input  wire logic                   reg_we,
	input  wire logic                   reg_re,
	input  wire logic                   reg_priv,
	output logic      [31:0]            reg_rdata,
	// core events
	input  wire logic [SHP_N_FAULT-1:0] fault_req,
	input  wire logic                   svc_req,
	input  wire logic                   enter_valid,
	input  wire shp_exc_t               enter_id,
	input  wire logic                   return_valid,
	input  wire shp_exc_t               return_id,
	// state to the prioritisation logic
	output logic      [7:0]             tick_priority_field,
	output logic      [7:0]             deferred_call_priority_field,
	output logic                        usage_fault_enable,
	output logic                        bus_fault_enable,
	output logic                        memmanage_fault_enable,
	output logic      [SHP_N_PEND-1:0]  pending_state,
	output logic      [SHP_N_ACT-1:0]   active_state,
	// escalation and hazard reporting
	output logic                        hardfault_req,
	output logic      [SHP_N_FAULT-1:0] hardfault_cause,
	output logic                        active_rewritten
);
	import shp_pkg::*;

	// address decode, gated by privilege
	logic        sel_prio;
	logic        sel_hcs;
	logic        wr_prio;
	logic        wr_hcs;
	logic [31:0] wmask;
	logic [31:0] hcs_word;
	logic [31:0] prio_word;

	// unprivileged accesses see nothing and change nothing [RQ15]
	assign sel_prio = (reg_addr == SHP_ADDR_PRIO) && reg_priv;
	assign sel_hcs  = (reg_addr == SHP_ADDR_HCS) && reg_priv;
	assign wr_prio  = reg_we && sel_prio;
	assign wr_hcs   = reg_we && sel_hcs;
	assign wmask    = shp_be_mask(reg_be);

	// priority fields, each on its own byte lane [RQ3]
	shp_prio_byte u_tick_prio (
		.core_clk (core_clk),
		.rstn     (rstn),
		.wr_en    (wr_prio && reg_be[SHP_TICK_LANE]),
		.wr_byte  (reg_wdata[31:24]),
		.field    (tick_priority_field)
	); // [RQ1]

	shp_prio_byte u_defer_prio (
		.core_clk (core_clk),
		.rstn     (rstn),
		.wr_en    (wr_prio && reg_be[SHP_DEFER_LANE]),
		.wr_byte  (reg_wdata[23:16]),
		.field    (deferred_call_priority_field)
	); // [RQ1]

	// lanes 1 and 0 of the priority word hold nothing, so writes there are dropped
	assign prio_word = {tick_priority_field, deferred_call_priority_field, 16'h0000}; // [RQ16]

	// fault enables
	logic [SHP_N_FAULT-1:0] ena_q;
	logic [SHP_N_FAULT-1:0] ena_d;

	always_comb begin
		ena_d = ena_q;
		for (int i = 0; i < SHP_N_FAULT; i++) begin
			if (wr_hcs && wmask[SHP_ENA_LSB + i]) begin
				ena_d[i] = reg_wdata[SHP_ENA_LSB + i]; // [RQ5]
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ena_q <= SHP_RST_ENA; // [RQ15]
		end else begin
			ena_q <= ena_d;
		end
	end

	assign memmanage_fault_enable = ena_q[0];
	assign bus_fault_enable       = ena_q[1];
	assign usage_fault_enable     = ena_q[2];

	// fault routing: enabled faults pend, disabled ones go to hard fault
	logic [SHP_N_FAULT-1:0] fault_ok;
	logic [SHP_N_FAULT-1:0] fault_esc;

	assign fault_ok  = fault_req & ena_q;
	assign fault_esc = fault_req & ~ena_q; // [RQ6]

	logic                   hf_q;
	logic                   hf_d;
	logic [SHP_N_FAULT-1:0] cause_q;
	logic [SHP_N_FAULT-1:0] cause_d;

	always_comb begin
		hf_d    = |fault_esc; // [RQ6]
		cause_d = cause_q;
		if (|fault_esc) begin
			cause_d = fault_esc;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hf_q    <= 1'b0;
			cause_q <= SHP_RST_ENA;
		end else begin
			hf_q    <= hf_d;
			cause_q <= cause_d;
		end
	end

	assign hardfault_req   = hf_q;
	assign hardfault_cause = cause_q;

	// pending flags: index 0 usage, 1 mem, 2 bus, 3 svc
	logic [SHP_N_PEND-1:0] pend_set;
	logic [SHP_N_PEND-1:0] pend_clr;

	assign pend_set = {svc_req, fault_ok[1], fault_ok[0], fault_ok[2]};
	assign pend_clr = enter_valid ? shp_pend_sel(enter_id) : 4'h0;

	for (genvar k = 0; k < SHP_N_PEND; k++) begin : g_pend
		shp_state_bit u_pend (
			.core_clk (core_clk),
			.rstn     (rstn),
			.sw_we    (wr_hcs && wmask[SHP_PEND_LSB + k]),
			.sw_val   (reg_wdata[SHP_PEND_LSB + k]),
			.hw_set   (pend_set[k]),
			.hw_clr   (pend_clr[k]),
			.state    (pending_state[k])
		); // [RQ7] [RQ8]
	end

	// active flags: mem, bus, usage, svc, monitor, deferred, tick
	logic [SHP_N_ACT-1:0] act_set;
	logic [SHP_N_ACT-1:0] act_clr;
	logic [SHP_N_ACT-1:0] act_we;
	logic [SHP_N_ACT-1:0] act_wv;

	assign act_set = enter_valid ? shp_act_sel(enter_id) : 7'h00;
	assign act_clr = return_valid ? shp_act_sel(return_id) : 7'h00;

	for (genvar k = 0; k < SHP_N_ACT; k++) begin : g_act
		localparam int P = shp_act_pos(k);
		assign act_we[k] = wr_hcs && wmask[P];
		assign act_wv[k] = reg_wdata[P];
		shp_state_bit u_act (
			.core_clk (core_clk),
			.rstn     (rstn),
			.sw_we    (act_we[k]),
			.sw_val   (act_wv[k]),
			.hw_set   (act_set[k]),
			.hw_clr   (act_clr[k]),
			.state    (active_state[k])
		); // [RQ9] [RQ10]
	end

	// flag a software change of active state so return checking can fault
	logic rew_q;
	logic rew_d;

	always_comb begin
		rew_d = |(act_we & (act_wv ^ active_state)); // [RQ11]
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rew_q <= 1'b0;
		end else begin
			rew_q <= rew_d;
		end
	end

	assign active_rewritten = rew_q;

	// readback of the control and state word; reserved positions stay zero
	always_comb begin
		hcs_word = SHP_RST_WORD;
		hcs_word[SHP_ENA_LSB +: SHP_N_FAULT] = ena_q;
		hcs_word[SHP_PEND_LSB +: SHP_N_PEND] = pending_state;
		for (int k = 0; k < SHP_N_ACT; k++) begin
			hcs_word[shp_act_pos(k)] = active_state[k];
		end
		hcs_word = hcs_word & SHP_HCS_MASK; // [RQ16]
	end

	// read data stands only in the cycle after the strobe
	logic [31:0] rd_q;
	logic [31:0] rd_d;

	always_comb begin
		rd_d = SHP_RST_WORD;
		if (reg_re && sel_prio) begin
			rd_d = prio_word;
		end else if (reg_re && sel_hcs) begin
			rd_d = hcs_word;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rd_q <= SHP_RST_WORD;
		end else begin
			rd_q <= rd_d;
		end
	end

	// every state output is a flop, so a write is seen one edge later [RQ17]
	assign reg_rdata = rd_q;

endmodule

// File: verification/shp_hs_sva.sv
// port assertions for the system handler state block
module shp_hs_sva
	import shp_pkg::*;
(
	// clock and reset
	input wire logic	core_clk,
	input wire logic	rstn,
	// register port
	input wire logic [31:0]	reg_addr,
	input wire logic [31:0]	reg_wdata,
	input wire logic [3:0]	reg_be,
	input wire logic	reg_we,
	input wire logic	reg_re,
	input wire logic	reg_priv,
	input wire logic [31:0]	reg_rdata,
	// core side
	input wire logic [2:0]	fault_req,
	input wire logic [7:0]	tick_priority_field,
	input wire logic [7:0]	deferred_call_priority_field,
	input wire logic	usage_fault_enable,
	input wire logic	bus_fault_enable,
	input wire logic [3:0]	pending_state,
	input wire logic	hardfault_req
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic	pw;
	assign pw = reg_we && reg_priv;

	AST_PRIO_LOW: assert property (
		(tick_priority_field[3:0] | deferred_call_priority_field[3:0]) == 4'h0)
		else $error("priority low nibble set");
	AST_UNPRIV: assert property (
		reg_re && !reg_priv |=> reg_rdata == 32'h0)
		else $error("unprivileged read data");
	AST_HCS_RSV: assert property (
		reg_re && reg_addr == SHP_ADDR_HCS |=> (reg_rdata & ~SHP_HCS_MASK) == 32'h0)
		else $error("reserved bit read as one");
	AST_RD_PRIO: assert property (
		reg_re && reg_priv && reg_addr == SHP_ADDR_PRIO |=>
		reg_rdata == {$past(tick_priority_field), $past(deferred_call_priority_field), 16'h0})
		else $error("priority read data");
	AST_PRIO_WR: assert property (
		pw && reg_addr == SHP_ADDR_PRIO && reg_be[3] |=>
		tick_priority_field == {$past(reg_wdata[31:28]), 4'h0})
		else $error("tick priority write lost");
	AST_ENA_WR: assert property (
		pw && reg_addr == SHP_ADDR_HCS && reg_be[2] |=>
		usage_fault_enable == $past(reg_wdata[18]))
		else $error("usage enable write lost");
	AST_ESC: assert property (
		fault_req[1] && !bus_fault_enable |=> hardfault_req)
		else $error("disabled fault not escalated");
	AST_PEND: assert property (
		fault_req[1] && bus_fault_enable |=> pending_state[2])
		else $error("bus fault not pending");
endmodule

bind shp_handler_state shp_hs_sva u_sva (
	.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_be, .reg_we, .reg_re, .reg_priv,
	.reg_rdata, .fault_req, .tick_priority_field, .deferred_call_priority_field,
	.usage_fault_enable, .bus_fault_enable, .pending_state, .hardfault_req
);

// File: verification/tb.sv
// self-checking bench for the system handler state block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import shp_pkg::*;
	logic		core_clk, rstn, reg_we, reg_re, reg_priv, svc_req;
	logic		enter_valid, return_valid, hardfault_req, active_rewritten;
	logic		usage_fault_enable, bus_fault_enable, memmanage_fault_enable;
	logic [31:0]	reg_addr, reg_wdata, reg_rdata;
	logic [3:0]	reg_be, pending_state;
	logic [2:0]	fault_req, hardfault_cause;
	logic [6:0]	active_state;
	logic [7:0]	tick_priority_field, deferred_call_priority_field;
	shp_exc_t	enter_id, return_id;
	int		err_total, n_compared;
	localparam logic [3:0] IDS [7] = '{4'h4, 4'h5, 4'h6, 4'hb, 4'hc, 4'he, 4'hf};
	localparam int POS [7] = '{0, 1, 3, 7, 8, 10, 11};

	shp_handler_state uut (
		.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_be, .reg_we, .reg_re, .reg_priv,
		.reg_rdata, .fault_req, .svc_req, .enter_valid, .enter_id, .return_valid,
		.return_id, .tick_priority_field, .deferred_call_priority_field,
		.usage_fault_enable, .bus_fault_enable, .memmanage_fault_enable, .pending_state,
		.active_state, .hardfault_req, .hardfault_cause, .active_rewritten
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_be <= be;
		reg_we <= 1'b1;
		@(posedge core_clk);
		reg_we <= 1'b0;
		#1;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge core_clk);
		reg_re <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	task automatic ev(input logic [2:0] f, input logic s, en, rt, input logic [3:0] id);
		@(posedge core_clk);
		fault_req <= f;
		svc_req <= s;
		enter_valid <= en;
		return_valid <= rt;
		enter_id <= shp_exc_t'(id);
		return_id <= shp_exc_t'(id);
		@(posedge core_clk);
		fault_req <= 3'h0;
		{svc_req, enter_valid, return_valid} <= 3'h0;
		#1;
	endtask

	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// the tests need about a hundred cycles
	initial begin
		#20000;
		err_total++;
		finish_test;
	end

	initial begin
		rstn = 1'b0;
		{reg_we, reg_re, svc_req, enter_valid, return_valid} = 5'h0;
		reg_priv = 1'b1;
		reg_addr = 32'h0;
		reg_wdata = 32'h0;
		reg_be = 4'h0;
		fault_req = 3'h0;
		enter_id = SHP_EXC_MEM;
		return_id = SHP_EXC_MEM;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		rd(SHP_ADDR_PRIO, 32'h0);
		rd(SHP_ADDR_HCS, 32'h0);
		$display("test reset done");
		wr(SHP_ADDR_PRIO, 32'ha5b60000, 4'hf);
		rd(SHP_ADDR_PRIO, 32'ha0b00000);
		wr(SHP_ADDR_PRIO, 32'h3c000000, 4'h8);
		chk({24'h0, tick_priority_field}, 32'h30);
		wr(SHP_ADDR_PRIO, 32'h00ff0000, 4'h4);
		rd(SHP_ADDR_PRIO, 32'h30f00000);
		reg_priv <= 1'b0;
		wr(SHP_ADDR_PRIO, 32'hffff0000, 4'hf);
		rd(SHP_ADDR_PRIO, 32'h0);
		reg_priv <= 1'b1;
		rd(SHP_ADDR_PRIO, 32'h30f00000);
		rd(32'he000ed28, 32'h0);
		$display("test priority done");
		wr(SHP_ADDR_HCS, 32'h0007fd8b, 4'hf);
		chk({31'h0, active_rewritten}, 32'h1);
		rd(SHP_ADDR_HCS, 32'h0007fd8b);
		chk({29'h0, usage_fault_enable, bus_fault_enable, memmanage_fault_enable}, 32'h7);
		wr(SHP_ADDR_HCS, 32'h0, 4'h1);
		rd(SHP_ADDR_HCS, 32'h0007fd00);
		wr(SHP_ADDR_HCS, 32'h0, 4'hf);
		rd(SHP_ADDR_HCS, 32'h0);
		$display("test control done");
		for (int i = 0; i < 3; i++) begin
			ev(3'(1 << i), 1'b0, 1'b0, 1'b0, 4'h5);
			chk({31'h0, hardfault_req}, 32'h1);
			chk({29'h0, hardfault_cause}, 32'h1 << i);
			chk({28'h0, pending_state}, 32'h0);
		end
		wr(SHP_ADDR_HCS, 32'h00070000, 4'h4);
		ev(3'h7, 1'b1, 1'b0, 1'b0, 4'h5);
		chk({31'h0, hardfault_req}, 32'h0);
		rd(SHP_ADDR_HCS, 32'h0007f000);
		wr(SHP_ADDR_HCS, 32'h0007a000, 4'hf);
		rd(SHP_ADDR_HCS, 32'h0007a000);
		wr(SHP_ADDR_HCS, 32'h00070000, 4'hf);
		$display("test escalation done");
		for (int k = 0; k < 7; k++) begin
			ev(3'h0, 1'b0, 1'b1, 1'b0, IDS[k]);
			chk({25'h0, active_state}, 32'h1 << k);
			rd(SHP_ADDR_HCS, 32'h00070000 | (32'h1 << POS[k]));
			ev(3'h0, 1'b0, 1'b0, 1'b1, IDS[k]);
			chk({25'h0, active_state}, 32'h0);
		end
		$display("test active done");
		finish_test;
	end
endmodule
